// *** src/pva_defines.vh ***
// Constants for the video converter output port
`ifndef PVA_DEFINES_VH
`define PVA_DEFINES_VH
`define PVA_WORD_W       10
`define PVA_SIGN_BIT     9
`define PVA_CLK_NS       8
`define PVA_VALID_NS     200
// 200 ns at 8 ns a cycle, sized to the timer
`define PVA_VALID_CYC    5'h19
`define PVA_TMR_W        5
// Pop, read register and output register follow; word lands on cycle 25
`define PVA_POP_AT       5'h03
`define PVA_SIGN_MASK    10'h200
`define PVA_PIPE_EXTRA   2'h2
`define PVA_FIFO_DEPTH   32
`define PVA_FIFO_AW      5
`define PVA_PEND_W       6
`define PVA_WORD_RST     10'h000
`endif

// *** src/pva_fifo.v ***
// Sample FIFO with registered read data
`timescale 1ns/1ns
`default_nettype none
module pva_fifo #(
    parameter W     = 10,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire          clk,
    input  wire          nrst,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data,
    output wire          out_data_valid
);
    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0]   count_q;
    reg [W-1:0]  rd_data_q;
    reg          rd_valid_q;
    wire         push;
    wire         pop;
    localparam [AW:0] FULL_COUNT = DEPTH;

    assign in_ready       = (count_q != FULL_COUNT);
    assign out_valid      = (count_q != {(AW+1){1'b0}});
    assign push           = in_valid && in_ready;
    assign pop            = out_ready && out_valid;
    assign out_data       = rd_data_q;
    assign out_data_valid = rd_valid_q;

    always @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_q   <= {AW{1'b0}};
            rd_ptr_q   <= {AW{1'b0}};
            count_q    <= {(AW+1){1'b0}};
            rd_data_q  <= {W{1'b0}};
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= pop;
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
            begin
                rd_ptr_q  <= rd_ptr_q + 1'b1;
                rd_data_q <= mem[rd_ptr_q];
            end
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule // pva_fifo
`default_nettype wire

// *** src/pva_top.v ***
// Digital output port of a pipelined 10-bit video converter
//
// What this block does
// - A sample's word appears only after it and two more encode commands, until a hold makes the FIFO drop samples.
// - Word for sample N valid two encode periods plus 200 ns after its command, if hold_out has stayed low.
// - Each result is ten parallel bits, held steady between updates.
// - Words are two's complement; the top bit is the input's sign.
// - No data-ready or valid strobe; encode commands and hold_out are the only timing references.
// - All zeros is one step above zero volts, all ones one step below.
// - Most positive input gives 0111111111, the largest positive word.
`timescale 1ns/1ns
`default_nettype none
`include "pva_defines.vh"
module pva_top (
    input  wire                    sys_clk,
    input  wire                    nrst,
    input  wire                    enc_cmd,
    input  wire [`PVA_WORD_W-1:0]  sample_code,
    input  wire                    hold_out,
    output wire [`PVA_WORD_W-1:0]  data_out,
    output wire                    accept_out
);
    reg  [`PVA_WORD_W-1:0] dat_q;
    reg                    enc_prev_q;
    reg  [`PVA_TMR_W-1:0]  tmr_q;
    reg  [1:0]             warm_q;
    reg  [`PVA_PEND_W-1:0] pend_q;
    reg                    accept_q;
    reg  [`PVA_PEND_W-1:0] pend_d;
    wire                   enc_rise;
    wire                   due;
    wire                   fifo_in_ready;
    wire                   fifo_out_valid;
    wire                   fifo_pop;
    wire [`PVA_WORD_W-1:0] fifo_data;
    wire                   fifo_data_valid;

    // Quantizer delivers offset binary; flipping the sign bit gives 2's complement
    function [`PVA_WORD_W-1:0] twos_complement_code;
        input [`PVA_WORD_W-1:0] offset_code;
        begin
            twos_complement_code = offset_code ^ `PVA_SIGN_MASK;
        end
    endfunction

    assign enc_rise   = enc_cmd && !enc_prev_q;
    assign due        = (tmr_q == `PVA_POP_AT);
    // Drain stalls under hold_out, so the FIFO can really fill
    assign fifo_pop   = (pend_q != {`PVA_PEND_W{1'b0}}) && fifo_out_valid && !hold_out;
    assign data_out   = dat_q;
    assign accept_out = accept_q;

    pva_fifo #(
        .W     (`PVA_WORD_W),
        .DEPTH (`PVA_FIFO_DEPTH),
        .AW    (`PVA_FIFO_AW)
    ) u_fifo (
        .clk            (sys_clk),
        .nrst           (nrst),
        .in_valid       (enc_rise),
        .in_ready       (fifo_in_ready),
        .in_data        (twos_complement_code(sample_code)),
        .out_valid      (fifo_out_valid),
        .out_ready      (fifo_pop),
        .out_data       (fifo_data),
        .out_data_valid (fifo_data_valid)
    );

    // Pops owed: one per encode once two earlier samples sit ahead
    always @*
    begin
        pend_d = pend_q;
        if (due && (warm_q == `PVA_PIPE_EXTRA))
            pend_d = pend_d + 1'b1;
        if (fifo_pop)
            pend_d = pend_d - 1'b1;
    end

    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            enc_prev_q <= 1'b0;
            tmr_q      <= {`PVA_TMR_W{1'b0}};
            warm_q     <= 2'h0;
            pend_q     <= {`PVA_PEND_W{1'b0}};
            dat_q      <= `PVA_WORD_RST;
            accept_q   <= 1'b0;
        end
        else
        begin
            enc_prev_q <= enc_cmd;
            accept_q   <= fifo_in_ready;
            pend_q     <= pend_d;
            // At 5 MHz the next command can land as the delay ends; reload wins
            if (enc_rise)
                tmr_q <= `PVA_VALID_CYC;
            else if (tmr_q != {`PVA_TMR_W{1'b0}})
                tmr_q <= tmr_q - 1'b1;
            if (due && (warm_q != `PVA_PIPE_EXTRA))
                warm_q <= warm_q + 1'b1;
            if (fifo_data_valid)
                dat_q <= fifo_data;
        end
    end
endmodule // pva_top
`default_nettype wire

// *** bench/pva_chk_asserts.sv ***
// Converter port checker
`timescale 1ns/1ns
`default_nettype none
module pva_chk (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       enc_cmd,
    input wire logic [9:0] sample_code,
    input wire logic       hold_out,
    input wire logic [9:0] data_out,
    input wire logic       accept_out
);
    logic [9:0] s1_q, s2_q, s3_q;
    logic [1:0] n_q;
    always @(posedge sys_clk or negedge nrst)
        if (!nrst)
            n_q <= 2'h0;
        else if ($rose(enc_cmd))
        begin
            {s3_q, s2_q, s1_q} <= {s2_q, s1_q, sample_code ^ 10'h200};
            n_q <= n_q | {n_q[0], 1'b1};
        end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_word_order: assert property ($rose(enc_cmd) && n_q[1] && !hold_out |->
        ##26 (hold_out || data_out == $past(s3_q, 2))) else $error("word order");
    a_no_early: assert property ($rose(enc_cmd) && n_q[1] && !hold_out |->
        ##25 $stable(data_out)) else $error("word too early");
    a_word_steady: assert property ($rose(enc_cmd) |->
        ##2 $stable(data_out)) else $error("word not steady");
    a_hold_stall: assert property ($past(hold_out, 2) |->
        $stable(data_out)) else $error("word moved under hold");
    a_first_words: assert property (!n_q[1] |->
        data_out == 10'h000) else $error("early warm-up word");
    a_accept_free: assert property (!hold_out && !$past(hold_out) && !$past(hold_out, 2)
        && $past(nrst) |-> accept_out) else $error("samples dropped");
endmodule // pva_chk
bind pva_top pva_chk chk (.*);
`default_nettype wire

// *** bench/pva_src.sv ***
// Encode source and capture register
`timescale 1ns/1ns
`default_nettype none
module pva_src (
    input  wire logic       sys_clk,
    input  wire logic [9:0] data_out,
    output var  logic       enc_cmd = 1'b0,
    output var  logic [9:0] cap_q
);
    task automatic encode(); // 25 cycles per pulse
        @(negedge sys_clk) enc_cmd = 1'b1;
        repeat (3) @(negedge sys_clk);
        enc_cmd = 1'b0;
        repeat (21) @(negedge sys_clk);
    endtask
    always @(negedge enc_cmd) cap_q <= data_out;
endmodule // pva_src
`default_nettype wire

// *** bench/pva_top_tb.sv ***
// Converter port bench
`timescale 1ns/1ns
`default_nettype none
module pva_top_tb;
    logic       sys_clk = 1'b0, nrst = 1'b0, hold_out = 1'b0;
    logic [9:0] sample_code = 10'h000;
    wire        enc_cmd, accept_out;
    wire  [9:0] data_out, cap_q;
    int         fail_count = 0, checks = 0;
    logic [9:0] rows [3][2] = '{'{10'h3FF, 10'h1FF}, '{10'h200, 10'h000}, '{10'h1FF, 10'h3FF}};
    always #4 sys_clk = ~sys_clk;
    pva_top dut (.*);
    pva_src src (.*);
    task automatic check(string nm, logic [9:0] seen, exp);
        checks++;
        if (seen !== exp)
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        fail_count += int'(seen !== exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            sample_code = rows[i % 3][0];
            src.encode();
            if (i > 2) // Warm-up words skipped
                check("word", cap_q, rows[i - 3][1]);
        end
        hold_out = 1'b1;
        repeat (36) src.encode();
        check("held", data_out, rows[2][1]);
        check("full", {9'h000, accept_out}, 10'h000);
        hold_out = 1'b0;
        for (int n = 0; n < 80 && accept_out !== 1'b1; n++)
            @(negedge sys_clk);
        check("drain", {9'h000, accept_out}, 10'h001);
        end_of_test();
    end
endmodule // pva_top_tb
`default_nettype wire
